// ---- logic/sfl_pkg.sv ----
package sfl_pkg;

    // Register byte addresses
    localparam logic [7:0]  ADDR_DENOM      = 8'h00;
    localparam logic [7:0]  ADDR_TIMING     = 8'h04;
    localparam logic [7:0]  ADDR_LOCK_RST   = 8'h08;
    localparam logic [7:0]  ADDR_POWER      = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS     = 8'h10;

    // Control-word geometry
    localparam int          WORD_W          = 24;
    localparam int          CTRL_LSB        = 0;
    localparam int          CTRL_W          = 4;
    localparam logic [3:0]  CTRL_TIMING     = 4'hd;
    localparam logic [3:0]  CTRL_LOCK_RST   = 4'hf;

    // Fastlock timing word fields
    localparam int          TOC_LSB         = 4;
    localparam int          TOC_W           = 14;
    localparam int          CPF_LSB         = 18;
    localparam int          CPF_W           = 4;
    localparam int          CSR_LSB         = 22;
    localparam int          CSR_W           = 2;

    // Lock-detect and reset word fields
    localparam int          MAIN_TRI_BIT    = 4;
    localparam int          AUX_TRI_BIT     = 5;
    localparam int          MAIN_RST_BIT    = 6;
    localparam int          AUX_RST_BIT     = 7;
    localparam int          PRESCALE_BIT    = 13;

    // Denominator register fields
    localparam int          DEN_LO_W        = 12;
    localparam int          DEN_HI_W        = 10;
    localparam int          DEN_W           = 22;
    localparam int          DEN_WIDE_BIT    = 22;

    // Power register and status fields
    localparam int          PWR_DOWN_BIT    = 0;
    localparam int          STAT_REMAIN_LSB = 16;
    localparam int          REMAIN_W        = 15;

    // Reset values
    localparam logic [13:0] TOC_RST         = 14'h0000;
    localparam logic [3:0]  CPF_RST         = 4'h0;
    localparam logic [1:0]  CSR_RST         = 2'h0;
    localparam logic [21:0] DEN_RST         = 22'h000000;
    localparam logic        PWR_DOWN_RST    = 1'b0;

    // Timeout codes and counts
    localparam logic [13:0] TOC_HIZ         = 14'h0000;
    localparam logic [13:0] TOC_MANUAL      = 14'h0001;
    localparam logic [13:0] TOC_LOW         = 14'h0002;
    localparam logic [13:0] TOC_HIGH        = 14'h0003;
    localparam logic [13:0] TOC_MIN_AUTO    = 14'h0004;
    localparam logic [1:0]  PRESCALE_LAST   = 2'h3;
    localparam logic [2:0]  CNT_RST_CYCLES  = 3'h4;

    typedef enum logic [1:0] {
        SFL_PWR_OFF   = 2'b00,
        SFL_PWR_RESET = 2'b01,
        SFL_PWR_ON    = 2'b10
    } sfl_pwr_state_t;

endpackage

// ---- logic/sfl_timer_if.sv ----
interface sfl_timer_if;
    logic        start;
    logic        cancel;
    logic        pdTick;
    logic [14:0] loadCount;
    logic        active;
    logic [14:0] remaining;

    modport timer (
        input  start,
        input  cancel,
        input  pdTick,
        input  loadCount,
        output active,
        output remaining
    );

    modport ctrl (
        output start,
        output cancel,
        output pdTick,
        output loadCount,
        input  active,
        input  remaining
    );
endinterface

// ---- logic/sfl_fastlock_timer.sv ----
module sfl_fastlock_timer
    import sfl_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  srst,
    input  wire logic  clkEn,
    // Control side
    sfl_timer_if.timer tmr
);
    logic [REMAIN_W-1:0] remain_r;

    // Start wins over the tick of the same cycle so a retune restarts cleanly
    always_ff @(posedge clock) begin
        if (srst) begin
            remain_r <= '0;
        end else if (clkEn) begin
            if (tmr.cancel) begin
                remain_r <= '0;
            end else if (tmr.start) begin
                remain_r <= tmr.loadCount;
            end else if (tmr.pdTick && remain_r != '0) begin
                remain_r <= remain_r - 15'h0001;
            end
        end
    end

    assign tmr.active    = (remain_r != '0);
    assign tmr.remaining = remain_r;
endmodule

// ---- logic/sfl_reset_control.sv ----
// Functional notes
// - With the wide-mode bit clear the denominator is the low 12 bits and the upper ten are ignored.
// - With the wide-mode bit set the denominator joins upper ten and lower twelve bits into 22 bits.
// - Timeout codes 0, 2 and 3 disable fastlock, code 1 forces it, and codes 0 to 3 make the fastlock pin a plain three-state output.
// - Timeout codes 4 to 16383 enable fastlock and the fastlock pin shows the fastlock state.
// - Fastlock lasts twice the timeout code in comparison cycles and then ends.
// - Code 0 floats the pin, 1 drives low and forces fastlock, 2 drives low, 3 drives high.
// - The fastlock pump current multiple is the 4-bit code plus one, used during fastlock.
// - Slip reduction code 0 is off and 1, 2, 3 reduce the sample rate by 1/2, 1/4, 1/16.
// - With the prescale bit set the main comparison ticks to lock detect are divided by 4.
// - The aux counter-reset bit holds the aux counters in reset and floats the aux pump.
// - The main counter-reset bit holds the main counters in reset and floats the main pump.
// - Every power-up, by software or by the chip-enable pin, applies a counter reset.
// - The main tri-state bit floats the main pump while counters run, and resets to 0.
module sfl_reset_control
    import sfl_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Synthesizer events, same clock
    input  wire logic                  pdTick,
    input  wire logic                  auxPdTick,
    input  wire logic                  retuneStrobe,
    // Chip-enable pin, asynchronous
    input  wire logic                  chipEnablePin,
    // Fastlock output pin
    input  wire logic                  fastlockPinIn,
    output logic                       fastlockPinOut,
    output logic                       fastlockPinOe,
    // Decoded controls to the synthesizer
    output logic [sfl_pkg::DEN_W-1:0]  fracDenominator,
    output logic                       fastlockActive,
    output logic [4:0]                 fastlockPumpMult,
    output logic                       slipReduceEnable,
    output logic [2:0]                 slipRateShift,
    output logic                       lockDetectTick,
    output logic                       auxLockDetectTick,
    output logic                       mainCounterReset,
    output logic                       mainPumpTristate,
    output logic                       auxCounterReset,
    output logic                       auxPumpTristate
);
    import sfl_pkg::*;

    sfl_timer_if tif ();

    // Programmed fields
    logic [DEN_W-1:0]   denom_r;
    logic               wideMode_r;
    logic [TOC_W-1:0]   fastlockTimeout_r;
    logic [CPF_W-1:0]   fastlockPumpCurrent_r;
    logic [CSR_W-1:0]   slipReduction_r;
    logic               lockDetectPrescale_r;
    logic               mainCounterRstBit_r;
    logic               auxCounterRstBit_r;
    logic               mainPumpTristateBit_r;
    logic               auxPumpTristateBit_r;
    logic               powerDown_r;

    // Bus decode
    logic               setupPhase;
    logic               accessWrite;
    logic               addrHit;
    logic               ctrlBad;
    logic [31:0]        readValue;
    logic               timingWrite;
    logic               lockRstWrite;

    // Pin synchronisers
    logic               ceMeta_r;
    logic               ceSync_r;
    logic               flInMeta_r;
    logic               flInSync_r;

    // Power-up sequencing
    sfl_pwr_state_t     pwrState_r;
    sfl_pwr_state_t     pwrState_nxt;
    logic [2:0]         rstHold_r;
    logic               chipOn;

    // Prescaler and fastlock
    logic [1:0]         prescaleCnt_r;
    logic               autoMode;
    logic               forceFastlock;
    logic               fastlockState;

    assign pready      = 1'b1;
    assign setupPhase  = psel && !penable;
    assign accessWrite = psel && penable && pwrite;

    // Control nibble must match the word it addresses
    always_comb begin
        addrHit = 1'b1;
        ctrlBad = 1'b0;
        case (paddr)
            ADDR_DENOM, ADDR_POWER, ADDR_STATUS: begin
                ctrlBad = 1'b0;
            end
            ADDR_TIMING: begin
                ctrlBad = pwrite && (pwdata[CTRL_LSB +: CTRL_W] != CTRL_TIMING);
            end
            ADDR_LOCK_RST: begin
                ctrlBad = pwrite && (pwdata[CTRL_LSB +: CTRL_W] != CTRL_LOCK_RST);
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    assign timingWrite  = accessWrite && paddr == ADDR_TIMING && !ctrlBad;
    assign lockRstWrite = accessWrite && paddr == ADDR_LOCK_RST && !ctrlBad;

    always_comb begin
        readValue = 32'h0000_0000;
        case (paddr)
            ADDR_DENOM: begin
                readValue[DEN_W-1:0]   = denom_r;
                readValue[DEN_WIDE_BIT] = wideMode_r;
            end
            ADDR_TIMING: begin
                readValue[CTRL_LSB +: CTRL_W] = CTRL_TIMING;
                readValue[TOC_LSB +: TOC_W]   = fastlockTimeout_r;
                readValue[CPF_LSB +: CPF_W]   = fastlockPumpCurrent_r;
                readValue[CSR_LSB +: CSR_W]   = slipReduction_r;
            end
            ADDR_LOCK_RST: begin
                readValue[CTRL_LSB +: CTRL_W] = CTRL_LOCK_RST;
                readValue[MAIN_TRI_BIT]       = mainPumpTristateBit_r;
                readValue[AUX_TRI_BIT]        = auxPumpTristateBit_r;
                readValue[MAIN_RST_BIT]       = mainCounterRstBit_r;
                readValue[AUX_RST_BIT]        = auxCounterRstBit_r;
                readValue[PRESCALE_BIT]       = lockDetectPrescale_r;
            end
            ADDR_POWER: begin
                readValue[PWR_DOWN_BIT] = powerDown_r;
            end
            ADDR_STATUS: begin
                readValue[0] = fastlockState;
                readValue[1] = flInSync_r;
                readValue[2] = mainCounterReset;
                readValue[3] = ceSync_r;
                readValue[4] = autoMode;
                readValue[STAT_REMAIN_LSB +: REMAIN_W] = tif.remaining;
            end
            default: begin
                readValue = 32'h0000_0000;
            end
        endcase
    end

    // Answer is prepared in the setup cycle so data leaves a flip-flop
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn && setupPhase) begin
            prdata  <= pwrite ? 32'h0000_0000 : readValue;
            pslverr <= !addrHit || ctrlBad;
        end
    end

    // Denominator word
    always_ff @(posedge clock) begin
        if (srst) begin
            denom_r    <= DEN_RST;
            wideMode_r <= 1'b0;
        end else if (clkEn && accessWrite && paddr == ADDR_DENOM) begin
            denom_r    <= pwdata[DEN_W-1:0];
            wideMode_r <= pwdata[DEN_WIDE_BIT];
        end
    end

    // Fastlock timing word
    always_ff @(posedge clock) begin
        if (srst) begin
            fastlockTimeout_r     <= TOC_RST;
            fastlockPumpCurrent_r <= CPF_RST;
            slipReduction_r       <= CSR_RST;
        end else if (clkEn && timingWrite) begin
            fastlockTimeout_r     <= pwdata[TOC_LSB +: TOC_W];
            fastlockPumpCurrent_r <= pwdata[CPF_LSB +: CPF_W];
            slipReduction_r       <= pwdata[CSR_LSB +: CSR_W];
        end
    end

    // Lock-detect and reset word; fixed bits are the host's concern
    always_ff @(posedge clock) begin
        if (srst) begin
            lockDetectPrescale_r  <= 1'b0;
            mainCounterRstBit_r   <= 1'b0;
            auxCounterRstBit_r    <= 1'b0;
            mainPumpTristateBit_r <= 1'b0;
            auxPumpTristateBit_r  <= 1'b0;
        end else if (clkEn && lockRstWrite) begin
            lockDetectPrescale_r  <= pwdata[PRESCALE_BIT];
            mainCounterRstBit_r   <= pwdata[MAIN_RST_BIT];
            auxCounterRstBit_r    <= pwdata[AUX_RST_BIT];
            mainPumpTristateBit_r <= pwdata[MAIN_TRI_BIT];
            auxPumpTristateBit_r  <= pwdata[AUX_TRI_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            powerDown_r <= PWR_DOWN_RST;
        end else if (clkEn && accessWrite && paddr == ADDR_POWER) begin
            powerDown_r <= pwdata[PWR_DOWN_BIT];
        end
    end

    // Two-flop synchronisers for the pins
    always_ff @(posedge clock) begin
        if (srst) begin
            ceMeta_r   <= 1'b0;
            ceSync_r   <= 1'b0;
            flInMeta_r <= 1'b0;
            flInSync_r <= 1'b0;
        end else if (clkEn) begin
            ceMeta_r   <= chipEnablePin;
            ceSync_r   <= ceMeta_r;
            flInMeta_r <= fastlockPinIn;
            flInSync_r <= flInMeta_r;
        end
    end

    // Power-up from either source lands in the reset state
    assign chipOn = ceSync_r && !powerDown_r;

    always_comb begin
        pwrState_nxt = pwrState_r;
        case (pwrState_r)
            SFL_PWR_OFF: begin
                if (chipOn) begin
                    pwrState_nxt = SFL_PWR_RESET;
                end
            end
            SFL_PWR_RESET: begin
                if (!chipOn) begin
                    pwrState_nxt = SFL_PWR_OFF;
                end else if (rstHold_r == 3'h1) begin
                    pwrState_nxt = SFL_PWR_ON;
                end
            end
            SFL_PWR_ON: begin
                if (!chipOn) begin
                    pwrState_nxt = SFL_PWR_OFF;
                end
            end
            default: begin
                pwrState_nxt = SFL_PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pwrState_r <= SFL_PWR_OFF;
        end else if (clkEn) begin
            pwrState_r <= pwrState_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rstHold_r <= 3'h0;
        end else if (clkEn) begin
            if (pwrState_r == SFL_PWR_OFF && chipOn) begin
                rstHold_r <= CNT_RST_CYCLES;
            end else if (rstHold_r != 3'h0) begin
                rstHold_r <= rstHold_r - 3'h1;
            end
        end
    end

    // Counter resets and pump three-state
    always_ff @(posedge clock) begin
        if (srst) begin
            mainCounterReset <= 1'b1;
            auxCounterReset  <= 1'b1;
            mainPumpTristate <= 1'b1;
            auxPumpTristate  <= 1'b1;
        end else if (clkEn) begin
            // Powered-down counters are also kept cleared
            mainCounterReset <= mainCounterRstBit_r
                                || pwrState_nxt != SFL_PWR_ON;
            auxCounterReset  <= auxCounterRstBit_r
                                || pwrState_nxt != SFL_PWR_ON;
            mainPumpTristate <= mainCounterRstBit_r || mainPumpTristateBit_r
                                || pwrState_nxt != SFL_PWR_ON;
            auxPumpTristate  <= auxCounterRstBit_r || auxPumpTristateBit_r
                                || pwrState_nxt != SFL_PWR_ON;
        end
    end

    // Lock-detect prescaler; the aux path is never divided
    always_ff @(posedge clock) begin
        if (srst) begin
            prescaleCnt_r     <= 2'h0;
            lockDetectTick    <= 1'b0;
            auxLockDetectTick <= 1'b0;
        end else if (clkEn) begin
            auxLockDetectTick <= auxPdTick;
            if (!lockDetectPrescale_r) begin
                prescaleCnt_r  <= 2'h0;
                lockDetectTick <= pdTick;
            end else if (pdTick) begin
                prescaleCnt_r  <= prescaleCnt_r + 2'h1;
                lockDetectTick <= (prescaleCnt_r == PRESCALE_LAST);
            end else begin
                lockDetectTick <= 1'b0;
            end
        end
    end

    // Fastlock timer, started by a timing write or a retune
    assign autoMode      = fastlockTimeout_r >= TOC_MIN_AUTO;
    assign forceFastlock = fastlockTimeout_r == TOC_MANUAL;

    assign tif.pdTick    = pdTick;
    assign tif.cancel    = mainCounterReset
                           || (timingWrite ? pwdata[TOC_LSB +: TOC_W] < TOC_MIN_AUTO
                                           : !autoMode);
    assign tif.start     = (timingWrite && pwdata[TOC_LSB +: TOC_W] >= TOC_MIN_AUTO)
                           || (retuneStrobe && autoMode);
    // Count in use is twice the code
    assign tif.loadCount = timingWrite ? {pwdata[TOC_LSB +: TOC_W], 1'b0}
                                       : {fastlockTimeout_r, 1'b0};

    sfl_fastlock_timer u_timer (
        .clock (clock),
        .srst  (srst),
        .clkEn (clkEn),
        .tmr   (tif.timer)
    );

    assign fastlockState = forceFastlock || (autoMode && tif.active);

    // Fastlock pin and decoded synthesizer controls
    always_ff @(posedge clock) begin
        if (srst) begin
            fastlockPinOut <= 1'b0;
            fastlockPinOe  <= 1'b0;
        end else if (clkEn) begin
            if (autoMode) begin
                fastlockPinOut <= tif.active;
                fastlockPinOe  <= 1'b1;
            end else begin
                case (fastlockTimeout_r[1:0])
                    TOC_HIZ[1:0]: begin
                        fastlockPinOut <= 1'b0;
                        fastlockPinOe  <= 1'b0;
                    end
                    TOC_HIGH[1:0]: begin
                        fastlockPinOut <= 1'b1;
                        fastlockPinOe  <= 1'b1;
                    end
                    default: begin
                        fastlockPinOut <= 1'b0;
                        fastlockPinOe  <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fastlockActive   <= 1'b0;
            fastlockPumpMult <= 5'h00;
        end else if (clkEn) begin
            fastlockActive   <= fastlockState;
            // Zero means steady-state current is in use
            fastlockPumpMult <= fastlockState
                                ? {1'b0, fastlockPumpCurrent_r} + 5'h01 : 5'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            slipReduceEnable <= 1'b0;
            slipRateShift    <= 3'h0;
        end else if (clkEn) begin
            slipReduceEnable <= slipReduction_r != 2'h0;
            case (slipReduction_r)
                2'h1:    slipRateShift <= 3'h1;
                2'h2:    slipRateShift <= 3'h2;
                2'h3:    slipRateShift <= 3'h4;
                default: slipRateShift <= 3'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fracDenominator <= DEN_RST;
        end else if (clkEn) begin
            fracDenominator <= wideMode_r ? denom_r
                               : {{DEN_HI_W{1'b0}}, denom_r[DEN_LO_W-1:0]};
        end
    end
endmodule

// ---- verif/sfl_checker_properties.sv ----
module sfl_checker
    import sfl_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Events and pins
    input wire logic        pdTick,
    input wire logic        auxPdTick,
    input wire logic        chipEnablePin,
    input wire logic        fastlockPinOut,
    input wire logic        fastlockPinOe,
    // Decoded controls
    input wire logic        fastlockActive,
    input wire logic [4:0]  fastlockPumpMult,
    input wire logic [2:0]  slipRateShift,
    input wire logic        lockDetectTick,
    input wire logic        auxLockDetectTick,
    input wire logic        mainCounterReset,
    input wire logic        mainPumpTristate,
    input wire logic        auxCounterReset,
    input wire logic        auxPumpTristate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    wire logic tmgAcc = psel && penable && pwrite && paddr == ADDR_TIMING
                        && pwdata[3:0] == CTRL_TIMING;

    a_slip_decode: assert property (
        tmgAcc |-> ##2 slipRateShift == ($past(pwdata[23:22], 2) == 2'h3 ? 3'h4
                                          : {1'b0, $past(pwdata[23:22], 2)}))
        else $error("slip shift wrong");
    a_fastlock_start: assert property (
        tmgAcc && pwdata[17:4] >= TOC_MIN_AUTO && !mainCounterReset
        |-> ##2 fastlockActive && fastlockPinOut && fastlockPinOe)
        else $error("fastlock did not start");
    a_pump_mult: assert property (
        fastlockActive == (fastlockPumpMult != 5'h00))
        else $error("pump multiple outside fastlock");
    a_main_tick: assert property (
        lockDetectTick |-> $past(pdTick))
        else $error("lock tick without comparison");
    a_aux_tick: assert property (
        !$past(srst) && !$past(auxCounterReset) |-> auxLockDetectTick == $past(auxPdTick))
        else $error("aux lock tick wrong");
    a_main_reset: assert property (
        mainCounterReset |-> mainPumpTristate)
        else $error("main pump driving in reset");
    a_aux_reset: assert property (
        auxCounterReset |-> auxPumpTristate)
        else $error("aux pump driving in reset");
    a_powerup_reset: assert property (
        $rose(chipEnablePin) |-> (mainCounterReset && auxCounterReset) [*5])
        else $error("no counter reset at power-up");
endmodule

bind sfl_reset_control sfl_checker sfl_checker_i (.*);

// ---- verif/sfl_pd_model.sv ----
module sfl_pd_model (
    // Clock and enable
    input  wire logic clock,
    input  wire logic run,
    // Comparison events
    output logic      pdTick,
    output logic      auxPdTick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] phase_r = 4'h0;

    // Main every 3rd cycle, aux every 5th; both fire at phase 6
    always_ff @(posedge clock) begin
        phase_r <= (phase_r == 4'he) ? 4'h0 : phase_r + 4'h1;
        pdTick <= run && (phase_r % 3 == 0);
        auxPdTick <= run && (phase_r % 5 == 1);
    end
endmodule

// ---- verif/sfl_testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sfl_pkg::*;
    logic              clock, srst, clkEn, psel, penable, pwrite, pready, pslverr, pdRun;
    logic              pdTick, auxPdTick, retuneStrobe, chipEnablePin, fastlockPinIn;
    logic              fastlockPinOut, fastlockPinOe, fastlockActive, slipReduceEnable;
    logic              lockDetectTick, auxLockDetectTick, mainCounterReset, mainPumpTristate;
    logic              auxCounterReset, auxPumpTristate;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic [DEN_W-1:0]  fracDenominator;
    logic [4:0]        fastlockPumpMult;
    logic [2:0]        slipRateShift;
    int                n_fail = 0;
    int                checks_done = 0;

    sfl_reset_control sfl_reset_control_i (.*);
    sfl_pd_model sfl_pd_model_i (.clock(clock), .run(pdRun), .pdTick(pdTick),
                                 .auxPdTick(auxPdTick));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic summarize();
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic guard(input bit out);
        if (out) begin
            n_fail++;
            summarize();
        end
    endtask

    // Full setup and access; one idle cycle after so psel never toggles twice at an edge
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic err,
                       input logic w = 1'b1);
        int k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        guard(k >= 16);
        chk(pslverr, err);
        if (!w) chk(prdata, d);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic t_pwr();
        chipEnablePin <= 1'b0;
        tick(10);
        chk({mainCounterReset, auxPumpTristate}, 2'h3);
        chipEnablePin <= 1'b1;
        tick(12);
        chk({mainCounterReset, auxCounterReset, mainPumpTristate}, 3'h0);
        bus(ADDR_POWER, 32'h1, 1'b0);
        bus(ADDR_POWER, 32'h0, 1'b0);
        tick(2);
        chk(mainCounterReset, 1'b1);
        tick(10);
    endtask

    task automatic t_den();
        for (int w = 0; w < 2; w++) begin
            bus(ADDR_DENOM, {9'h000, w[0], 22'h3fffff}, 1'b0);
            tick(1);
            chk(fracDenominator, w ? 22'h3fffff : 22'h000fff);
            bus(ADDR_DENOM, {9'h000, w[0], 22'h3fffff}, 1'b0, 1'b0);
        end
    endtask

    task automatic t_codes();
        for (int i = 0; i < 4; i++) begin
            bus(ADDR_TIMING, {8'h00, i[1:0], 4'h7, 12'h000, i[1:0], CTRL_TIMING}, 1'b0);
            tick(1);
            chk({fastlockPinOe, fastlockActive}, {i != 0, i == 1});
            if (i != 0) chk(fastlockPinOut, i == 3);
            chk(fastlockPumpMult, i == 1 ? 5'h08 : 5'h00);
            chk({slipReduceEnable, slipRateShift}, {i != 0, i == 3 ? 3'h4 : 3'(i)});
        end
        bus(ADDR_TIMING, 32'h0000_0050, 1'b1);
        tick(1);
        chk(fastlockActive, 1'b0);
        bus(8'h14, 32'h0, 1'b1);
    endtask

    task automatic t_fast();
        int n = 0;
        int k = 0;
        bus(ADDR_TIMING, {8'h00, 2'h0, 4'hf, 14'h0005, CTRL_TIMING}, 1'b0);
        pdRun <= 1'b1;
        tick(1);
        chk({fastlockActive, fastlockPinOut, fastlockPumpMult}, 7'h70);
        while (fastlockActive === 1'b1 && k < 100) begin
            @(posedge clock);
            n += pdTick;
            k++;
        end
        guard(k >= 100);
        chk(n, 10);
        chk({fastlockPinOe, fastlockPinOut, fastlockPumpMult}, 7'h40);
        retuneStrobe <= 1'b1;
        tick(1);
        retuneStrobe <= 1'b0;
        tick(2);
        chk(fastlockActive, 1'b1);
    endtask

    task automatic t_ticks();
        for (int p = 0; p < 2; p++) begin
            int n = 0;
            int m = 0;
            int k = 0;
            // Prescale off in the first pass and on in the second as for a fast comparison rate; bit 11 is the fixed one
            bus(ADDR_LOCK_RST, {18'h0, p[0], 13'h080f}, 1'b0);
            while (lockDetectTick !== 1'b1 && k < 100) begin
                @(posedge clock);
                k++;
            end
            while (m < 3 && k < 200) begin
                @(posedge clock);
                k++;
                n += pdTick;
                m += lockDetectTick;
            end
            guard(m < 3);
            chk(n, p ? 12 : 3);
        end
        pdRun <= 1'b0;
    endtask

    task automatic t_rst();
        for (int b = 0; b < 5; b++) begin
            logic [3:0] v = (b < 4) ? (4'h1 << b) : 4'h0;
            logic [3:0] e = {v[3], v[2], v[3] | v[1], v[2] | v[0]};
            bus(ADDR_LOCK_RST, {24'h000008, v, 4'hf}, 1'b0);
            tick(1);
            chk({auxCounterReset, mainCounterReset, auxPumpTristate, mainPumpTristate}, e);
        end
    endtask

    initial begin
        {srst, clkEn, chipEnablePin} = 3'h7;
        {psel, penable, pwrite, retuneStrobe, fastlockPinIn, pdRun} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        tick(4);
        srst <= 1'b0;
        tick(1);
        t_pwr();
        t_den();
        t_codes();
        t_fast();
        t_ticks();
        t_rst();
        summarize();
    end
endmodule
